// >>> operand_addr_map.svh
// register indices, width codes and reset values for the operand address block
`ifndef OPERAND_ADDR_MAP_SVH
`define OPERAND_ADDR_MAP_SVH
`define REG_BC        3'h0
`define REG_DE        3'h1
`define REG_HL        3'h2
`define REG_IX        3'h3
`define REG_IY        3'h4
`define REG_SP        3'h5
`define REG_COUNT     6
`define W_BYTE        2'h0
`define W_WORD        2'h1
`define W_LONG        2'h2
`define BYTES_BYTE    3'h1
`define BYTES_WORD    3'h2
`define BYTES_LONG    3'h4
`define REG_RESET     32'h0000_0000
`define PC_RESET      32'h0000_0000
`endif

// >>> operand_addr_pkg.sv
// types for the operand address block
package operand_addr_pkg;
    typedef enum logic [2:0] {
        AM_REG   = 3'h0,
        AM_IMM   = 3'h1,
        AM_IND   = 3'h2,
        AM_DIR   = 3'h3,
        AM_IDX   = 3'h4,
        AM_PCREL = 3'h5,
        AM_SPREL = 3'h6
    } addr_mode_t;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_FETCH = 3'h1,
        ST_CALC  = 3'h3,
        ST_MEM   = 3'h2,
        ST_DONE  = 3'h6
    } state_t;
endpackage : operand_addr_pkg

// >>> operand_address_generation.sv
// operand location and effective address generation with its register file
//
// Notes on behaviour
// - seven operand modes: register, immediate, indirect, direct, indexed, pc and sp relative.
// - register operand is register contents; long only by global setting or directive.
// - word register load writes bits 15..0 and keeps the upper half.
// - long register load copies all 32 source bits.
// - immediates come from instruction bytes; directives widen them to 24 or 32 bits.
// - a 24-bit immediate loaded long gets a zero top byte.
// - indirect address from chosen pair for memory, from C for I/O space.
// - indirect address is full 32 bits; upper halves reset to zero.
// - direct address from instruction, I/O or memory; jumps load it into pc.
// - directives extend a direct address to 24 or 32 bits.
// - direct load width is 16 bits in word width, 32 in long width.
// - unextended direct address has bits 31..16 zero; word read low byte first.
// - long memory operand from four ascending bytes, lowest byte first.
// - indexed address is index register plus signed 8-bit displacement.
// - displacement widens to 16 or 24 bits by byte or word directive.
// - native indexed sum wraps at 16 bits, no carry into upper half.
// - native displacement sign-extended to 16; upper bits kept from index register.
// - extended mode sign-extends to 32 and wraps at 32 bits.
// - relative transfer loads pc plus signed 8, 16 or 24-bit displacement.
// - native relative target wraps at 16 bits with pc 31..16 zero.
// - directive adds one byte or word after the existing immediate bytes.
// - immediate bytes not supplied read as zero.
`timescale 1ns/100ps
`include "operand_addr_map.svh"
module operand_address_generation
    import operand_addr_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    // global modes
    input  wire logic        set_global_wide_width_i,
    input  wire logic        clear_global_wide_width_i,
    input  wire logic        enter_extended_addressing_i,
    output logic             long_word_width_setting_o,
    output logic             extended_mode_o,
    // request, held stable from start until done
    input  wire logic        start_i,
    input  wire addr_mode_t  addr_mode_i,
    input  wire logic        io_space_i,
    input  wire logic        jump_i,
    input  wire logic        opcode_word_i,
    input  wire logic        extra_byte_directive_i,
    input  wire logic        extra_word_directive_i,
    input  wire logic        word_directive_i,
    input  wire logic        long_directive_i,
    input  wire logic [1:0]  base_bytes_i,
    input  wire logic [2:0]  src_sel_i,
    input  wire logic [2:0]  dst_sel_i,
    input  wire logic        dst_we_i,
    input  wire logic [31:0] pc_i,
    // instruction byte stream
    input  wire logic [7:0]  ibyte_i,
    input  wire logic        ibyte_valid_i,
    output logic             ibyte_ready_o,
    // byte-wide memory and I/O read
    output logic             mem_req_o,
    output logic [31:0]      mem_addr_o,
    output logic             mem_io_o,
    input  wire logic [7:0]  mem_rdata_i,
    input  wire logic        mem_ack_i,
    // results
    output logic             done_o,
    output logic [31:0]      operand_o,
    output logic [31:0]      ea_o,
    output logic [31:0]      pc_o,
    output logic             pc_load_o,
    // register file access
    input  wire logic        reg_wr_i,
    input  wire logic [2:0]  reg_wr_sel_i,
    input  wire logic [31:0] reg_wr_data_i,
    input  wire logic [2:0]  reg_rd_sel_i,
    output logic [31:0]      reg_rd_data_o
);
    function automatic logic [31:0] sext(input logic [31:0] v, input logic [2:0] n);
        case (n)
            3'h1:    sext = {{24{v[7]}}, v[7:0]};
            3'h2:    sext = {{16{v[15]}}, v[15:0]};
            3'h3:    sext = {{8{v[23]}}, v[23:0]};
            default: sext = v;
        endcase
    endfunction : sext
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nv, input logic [1:0] w);
        case (w)
            `W_BYTE: merge = {old[31:8], nv[7:0]};
            `W_WORD: merge = {old[31:16], nv[15:0]};
            default: merge = nv;
        endcase
    endfunction : merge
    state_t      state_reg, state_next;
    logic        lw_reg, lw_next, xm_reg, xm_next;
    logic [2:0]  cnt_reg, cnt_next;
    logic [31:0] imm_reg, imm_next;
    logic [31:0] op_reg, op_next;
    logic [31:0] ea_reg, ea_next;
    logic [31:0] maddr_reg, maddr_next;
    logic        mio_reg, mio_next;
    logic [31:0] pc_reg, pc_next;
    logic        pcl_reg, pcl_next;
    logic [31:0] regs_reg  [0:`REG_COUNT-1];
    logic [31:0] regs_next [0:`REG_COUNT-1];
    logic        eff_long;
    logic [1:0]  wsel;
    logic [2:0]  need, mbytes;
    logic [31:0] disp, base, wr_val;
    logic        wr_en;
    // one-shot directive beats the global setting without touching it
    assign eff_long = long_directive_i ? 1'b1 : (word_directive_i ? 1'b0 : lw_reg);
    assign wsel     = !opcode_word_i ? `W_BYTE : (eff_long ? `W_LONG : `W_WORD);
    assign mbytes   = !opcode_word_i ? `BYTES_BYTE : (eff_long ? `BYTES_LONG : `BYTES_WORD);
    // word directive wins if both extension directives are given
    assign need     = {1'b0, base_bytes_i} + (extra_word_directive_i ? 3'h2 :
                      (extra_byte_directive_i ? 3'h1 : 3'h0));
    assign disp     = sext(imm_reg, need);
    assign base     = (addr_mode_i == AM_SPREL) ? regs_reg[`REG_SP] : regs_reg[src_sel_i];
    always_comb
    begin
        state_next = state_reg;
        lw_next    = lw_reg;
        xm_next    = xm_reg | enter_extended_addressing_i;
        cnt_next   = cnt_reg;
        imm_next   = imm_reg;
        op_next    = op_reg;
        ea_next    = ea_reg;
        maddr_next = maddr_reg;
        mio_next   = mio_reg;
        pc_next    = pc_reg;
        pcl_next   = 1'b0;
        wr_en      = 1'b0;
        wr_val     = 32'h0000_0000;
        if (set_global_wide_width_i)
            lw_next = 1'b1;
        else if (clear_global_wide_width_i)
            lw_next = 1'b0;
        unique case (state_reg)
            ST_IDLE:
            begin
                cnt_next = 3'h0;
                imm_next = 32'h0000_0000;
                if (start_i)
                    state_next = ST_FETCH;
            end
            ST_FETCH:
            begin
                if (cnt_reg == need)
                begin
                    cnt_next   = 3'h0;
                    state_next = ST_CALC;
                end
                else if (ibyte_valid_i)
                begin
                    imm_next[cnt_reg[1:0]*8 +: 8] = ibyte_i;
                    cnt_next = cnt_reg + 3'h1;
                end
            end
            ST_CALC:
            begin
                state_next = ST_DONE;
                unique case (addr_mode_i)
                    AM_REG:
                    begin
                        op_next = regs_reg[src_sel_i];
                        wr_en   = dst_we_i;
                        wr_val  = merge(regs_reg[dst_sel_i], regs_reg[src_sel_i], wsel);
                    end
                    AM_IMM:
                    begin
                        op_next = imm_reg;
                        wr_en   = dst_we_i;
                        wr_val  = merge(regs_reg[dst_sel_i], imm_reg, wsel);
                    end
                    AM_IND:
                    begin
                        // full 32-bit pointer, C alone for I/O
                        ea_next    = io_space_i ? {24'h00_0000, regs_reg[`REG_BC][7:0]}
                                                : regs_reg[src_sel_i];
                        state_next = ST_MEM;
                    end
                    AM_DIR:
                    begin
                        ea_next = imm_reg;
                        if (jump_i)
                        begin
                            pc_next  = imm_reg;
                            pcl_next = 1'b1;
                        end
                        else
                            state_next = ST_MEM;
                    end
                    AM_IDX, AM_SPREL:
                    begin
                        if (xm_reg)
                            ea_next = base + disp;
                        else
                            ea_next = {base[31:16], base[15:0] + disp[15:0]};
                        state_next = ST_MEM;
                    end
                    AM_PCREL:
                    begin
                        if (xm_reg)
                            pc_next = pc_i + disp;
                        else
                            pc_next = {16'h0000, pc_i[15:0] + disp[15:0]};
                        pcl_next = 1'b1;
                    end
                    default:
                        state_next = ST_DONE;
                endcase
                maddr_next = ea_next;
                mio_next   = io_space_i && (addr_mode_i == AM_IND || addr_mode_i == AM_DIR);
                op_next    = (state_next == ST_MEM) ? 32'h0000_0000 : op_next;
            end
            ST_MEM:
            begin
                if (mem_ack_i)
                begin
                    // ascending addresses, first byte is least significant
                    op_next[cnt_reg[1:0]*8 +: 8] = mem_rdata_i;
                    maddr_next = maddr_reg + 32'h0000_0001;
                    cnt_next   = cnt_reg + 3'h1;
                    if (cnt_next == mbytes)
                    begin
                        wr_en      = dst_we_i;
                        wr_val     = merge(regs_reg[dst_sel_i], op_next, wsel);
                        state_next = ST_DONE;
                    end
                end
            end
            ST_DONE:
                state_next = ST_IDLE;
            default:
                state_next = ST_IDLE;
        endcase
    end
    always_comb
    begin
        regs_next = regs_reg;
        if (wr_en)
            regs_next[dst_sel_i] = wr_val;
        else if (reg_wr_i && state_reg == ST_IDLE)
            regs_next[reg_wr_sel_i] = reg_wr_data_i;
    end
    // upper halves start at zero so pointers behave as 16-bit ones
    generate
        for (genvar g = 0; g < `REG_COUNT; g++)
        begin : gen_regs
            always_ff @(posedge clk_i or negedge reset_n_i)
            begin
                if (!reset_n_i)
                    regs_reg[g] <= `REG_RESET;
                else
                    regs_reg[g] <= regs_next[g];
            end
        end
    endgenerate
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state_reg <= ST_IDLE;
            lw_reg    <= 1'b0;
            xm_reg    <= 1'b0;
            cnt_reg   <= 3'h0;
            imm_reg   <= 32'h0000_0000;
            op_reg    <= 32'h0000_0000;
            ea_reg    <= 32'h0000_0000;
            maddr_reg <= 32'h0000_0000;
            mio_reg   <= 1'b0;
            pc_reg    <= `PC_RESET;
            pcl_reg   <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            lw_reg    <= lw_next;
            xm_reg    <= xm_next;
            cnt_reg   <= cnt_next;
            imm_reg   <= imm_next;
            op_reg    <= op_next;
            ea_reg    <= ea_next;
            maddr_reg <= maddr_next;
            mio_reg   <= mio_next;
            pc_reg    <= pc_next;
            pcl_reg   <= pcl_next;
        end
    end
    assign ibyte_ready_o             = (state_reg == ST_FETCH) && (cnt_reg != need);
    assign mem_req_o                 = (state_reg == ST_MEM);
    assign mem_addr_o                = maddr_reg;
    assign mem_io_o                  = mio_reg;
    assign done_o                    = (state_reg == ST_DONE);
    assign operand_o                 = op_reg;
    assign ea_o                      = ea_reg;
    assign pc_o                      = pc_reg;
    assign pc_load_o                 = pcl_reg;
    assign long_word_width_setting_o = lw_reg;
    assign extended_mode_o           = xm_reg;
    assign reg_rd_data_o             = regs_reg[reg_rd_sel_i];
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    a_word_keeps_upper: assert property (wr_en && wsel == `W_WORD |=>
        regs_reg[$past(dst_sel_i)][31:16] == $past(regs_reg[dst_sel_i][31:16]))
        else $error("word load changed upper half");
    a_long_copies_all: assert property (state_reg == ST_CALC && addr_mode_i == AM_REG && wr_en
        && wsel == `W_LONG |=> regs_reg[$past(dst_sel_i)] == $past(regs_reg[src_sel_i]))
        else $error("long register load not a full copy");
    a_imm24_top_zero: assert property (state_reg == ST_CALC && addr_mode_i == AM_IMM && need == 3'h3
        |=> op_reg[31:24] == 8'h00)
        else $error("24-bit immediate top byte not zero");
    a_direct_high_zero: assert property (state_reg == ST_CALC && addr_mode_i == AM_DIR && need == 3'h2
        |=> ea_reg[31:16] == 16'h0000)
        else $error("unextended direct address high bits set");
    a_native_idx_upper: assert property (state_reg == ST_CALC && addr_mode_i == AM_IDX && !xm_reg
        |=> ea_reg[31:16] == $past(regs_reg[src_sel_i][31:16]))
        else $error("native indexed address touched upper half");
    a_ext_idx_sum: assert property (state_reg == ST_CALC && addr_mode_i == AM_IDX && xm_reg
        |=> ea_reg == $past(regs_reg[src_sel_i]) + $past(disp))
        else $error("extended indexed address wrong");
    a_native_pc_zero: assert property (state_reg == ST_CALC && addr_mode_i == AM_PCREL && !xm_reg
        |=> pc_load_o && pc_o[31:16] == 16'h0000)
        else $error("native relative target upper bits set");
    a_fetch_bounded: assert property (state_reg == ST_FETCH |-> cnt_reg <= need)
        else $error("fetched more bytes than directed");
    a_mem_first_addr: assert property ($rose(mem_req_o) |-> mem_addr_o == ea_reg)
        else $error("memory read does not start at lowest address");
    a_global_kept: assert property (done_o && !set_global_wide_width_i && !clear_global_wide_width_i
        |=> long_word_width_setting_o == $past(long_word_width_setting_o))
        else $error("directive changed the global width");
    a_ext_sticky: assert property (xm_reg |=> xm_reg)
        else $error("extended mode left without reset");

    c_long_mem_read: cover property (state_reg == ST_MEM && mem_ack_i && cnt_reg == 3'h3);
    c_ext_indexed:   cover property (state_reg == ST_CALC && addr_mode_i == AM_IDX && xm_reg);
    c_native_rel:    cover property (state_reg == ST_CALC && addr_mode_i == AM_PCREL && !xm_reg);
endmodule : operand_address_generation

// >>> operand_address_generation_test.sv
// self-checking testbench for the operand address block
`timescale 1ns/100ps
`include "operand_addr_map.svh"
module operand_address_generation_test
    import operand_addr_pkg::*;
;
    localparam logic [7:0] F_IO = 8'h01, F_JMP = 8'h02, F_OPW = 8'h04, F_XB = 8'h08;
    localparam logic [7:0] F_XW = 8'h10, F_WD = 8'h20, F_LD = 8'h40, F_WE = 8'h80;
    logic        clk_i, reset_n_i, set_gw, clr_gw, ext_go, gw_o, ext_o, start_i;
    addr_mode_t  addr_mode_i;
    logic        io_i, jump_i, opw_i, xb_i, xw_i, wd_i, ld_i, we_i, ready_o;
    logic [1:0]  base_i;
    logic [2:0]  src_i, dst_i, wsel_i, rsel_i, bidx;
    logic [31:0] pc_i, wdata_i, rdata_o, operand_o, ea_o, pc_o, maddr_o, ibytes;
    logic [7:0]  ibyte_i, mrdata_i;
    logic        mreq_o, mio_o, done_o, pcl_o, reg_wr_i, last_io, got_pcl;
    int          nmem, n_errors, compares;
    logic [7:0]  mem [logic [31:0]];

    operand_address_generation u_dut (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .set_global_wide_width_i(set_gw),
        .clear_global_wide_width_i(clr_gw), .enter_extended_addressing_i(ext_go),
        .long_word_width_setting_o(gw_o), .extended_mode_o(ext_o), .start_i(start_i),
        .addr_mode_i(addr_mode_i), .io_space_i(io_i), .jump_i(jump_i), .opcode_word_i(opw_i),
        .extra_byte_directive_i(xb_i), .extra_word_directive_i(xw_i), .word_directive_i(wd_i),
        .long_directive_i(ld_i), .base_bytes_i(base_i), .src_sel_i(src_i), .dst_sel_i(dst_i),
        .dst_we_i(we_i), .pc_i(pc_i), .ibyte_i(ibyte_i), .ibyte_valid_i(1'b1),
        .ibyte_ready_o(ready_o), .mem_req_o(mreq_o), .mem_addr_o(maddr_o), .mem_io_o(mio_o),
        .mem_rdata_i(mrdata_i), .mem_ack_i(1'b1), .done_o(done_o), .operand_o(operand_o),
        .ea_o(ea_o), .pc_o(pc_o), .pc_load_o(pcl_o), .reg_wr_i(reg_wr_i), .reg_wr_sel_i(wsel_i),
        .reg_wr_data_i(wdata_i), .reg_rd_sel_i(rsel_i), .reg_rd_data_o(rdata_o)
    );

    // unsupplied stream bytes and unmapped memory show a pattern, never a stale value
    function automatic logic [7:0] mem_byte(input logic [31:0] a);
        return mem.exists(a) ? mem[a] : 8'h5A;
    endfunction : mem_byte
    assign mrdata_i = mem_byte(maddr_o);
    assign ibyte_i  = (bidx < 3'h4) ? ibytes[8 * bidx +: 8] : 8'hA5;

    always @(posedge clk_i)
    begin
        if (ready_o)
            bidx <= bidx + 3'h1;
        if (mreq_o)
        begin
            nmem    <= nmem + 1;
            last_io <= mio_o;
        end
    end

    initial
    begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic finish_test();
        if (n_errors == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : finish_test

    task automatic wr(input logic [2:0] sel, input logic [31:0] d);
        @(posedge clk_i);
        reg_wr_i <= 1'b1;
        wsel_i   <= sel;
        wdata_i  <= d;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask : wr

    task automatic rd(input string what, input logic [2:0] sel, input logic [31:0] exp);
        @(posedge clk_i);
        rsel_i <= sel;
        @(negedge clk_i);
        chk(what, exp, rdata_o);
    endtask : rd

    task automatic pulse(input int which);
        @(posedge clk_i);
        set_gw <= (which == 0);
        clr_gw <= (which == 1);
        ext_go <= (which == 2);
        @(posedge clk_i);
        {set_gw, clr_gw, ext_go} <= 3'h0;
        @(negedge clk_i);
    endtask : pulse

    // fields stay put from start until done, as the handshake demands
    task automatic go(input addr_mode_t m, input logic [2:0] src, input logic [2:0] dst,
                      input logic [1:0] base, input logic [7:0] f, input logic [31:0] bytes,
                      input logic [31:0] pc);
        int n;
        @(posedge clk_i);
        addr_mode_i <= m;
        src_i       <= src;
        dst_i       <= dst;
        base_i      <= base;
        {ld_i, wd_i, xw_i, xb_i, opw_i, jump_i, io_i} <= f[6:0];
        we_i        <= f[7];
        ibytes      <= bytes;
        pc_i        <= pc;
        bidx        <= 3'h0;
        nmem        <= 0;
        start_i     <= 1'b1;
        @(posedge clk_i);
        start_i <= 1'b0;
        n = 0;
        do
        begin
            @(negedge clk_i);
            n++;
        end
        while (done_o !== 1'b1 && n < 60);
        if (n >= 60)
        begin
            n_errors++;
            finish_test();
        end
        got_pcl = pcl_o;
        @(posedge clk_i);
        @(negedge clk_i);
    endtask : go

    task automatic s_global_width();
        pulse(0);
        chk("global set", 32'h1, gw_o);
        go(AM_REG, `REG_HL, `REG_BC, 2'h0, F_OPW | F_WD | F_WE, 32'h0, 32'h0);
        chk("reg operand", 32'h9ABC_DEF0, operand_o);
        rd("word reg load", `REG_BC, 32'h1234_DEF0);
        chk("global kept", 32'h1, gw_o);
        go(AM_DIR, 3'h0, `REG_DE, 2'h2, F_OPW | F_XW | F_WE, 32'h1234_5E22, 32'h0);
        chk("long reads", 32'h4, nmem);
        chk("long operand", 32'h0705_0301, operand_o);
        chk("ext direct ea", 32'h1234_5E22, ea_o);
        rd("long mem load", `REG_DE, 32'h0705_0301);
        pulse(1);
        chk("global clear", 32'h0, gw_o);
    endtask : s_global_width

    task automatic s_loads();
        go(AM_REG, `REG_HL, `REG_BC, 2'h0, F_OPW | F_LD | F_WE, 32'h0, 32'h0);
        rd("long reg load", `REG_BC, 32'h9ABC_DEF0);
        go(AM_DIR, 3'h0, `REG_BC, 2'h2, F_OPW | F_WE, 32'h0000_5E22, 32'h0);
        chk("word reads", 32'h2, nmem);
        chk("short direct ea", 32'h0000_5E22, ea_o);
        rd("word mem load", `REG_BC, 32'h9ABC_0301);
        // the stream byte after the instruction must not leak into the top byte
        go(AM_IMM, 3'h0, `REG_HL, 2'h2, F_OPW | F_XB | F_LD | F_WE, 32'hFF12_3456, 32'h0);
        rd("imm 24 load", `REG_HL, 32'h0012_3456);
        chk("imm operand", 32'h0012_3456, operand_o);
        go(AM_IMM, 3'h0, `REG_DE, 2'h2, F_OPW | F_XW | F_LD | F_WE, 32'h1234_5678, 32'h0);
        rd("imm 32 load", `REG_DE, 32'h1234_5678);
        go(AM_DIR, 3'h0, 3'h0, 2'h2, F_JMP, 32'h0000_1234, 32'h0);
        chk("jump target", 32'h0000_1234, pc_o);
        chk("jump load", 32'h1, got_pcl);
        go(AM_DIR, 3'h0, 3'h0, 2'h2, F_IO | F_XB, 32'hFF34_5E22, 32'h0);
        chk("direct 24 ea", 32'h0034_5E22, ea_o);
        chk("direct io space", 32'h1, last_io);
    endtask : s_loads

    task automatic s_indirect();
        go(AM_IND, `REG_BC, 3'h0, 2'h0, F_IO, 32'h0, 32'h0);
        chk("io ea", 32'h0000_0001, ea_o);
        chk("io operand", 32'h3C, operand_o[7:0]);
        chk("io space", 32'h1, last_io);
        wr(`REG_HL, 32'h1234_5678);
        go(AM_IND, `REG_HL, 3'h0, 2'h0, 8'h00, 32'h0, 32'h0);
        chk("ind ea", 32'h1234_5678, ea_o);
        chk("ind operand", 32'h0B, operand_o[7:0]);
        chk("mem space", 32'h0, last_io);
    endtask : s_indirect

    task automatic s_relative(input logic ext);
        go(AM_IDX, `REG_IX, 3'h0, 2'h1, 8'h00, 32'h0000_00FF, 32'h0);
        chk("idx ea", ext ? 32'h0000_FFFF : 32'h0001_FFFF, ea_o);
        go(AM_IDX, `REG_IX, 3'h0, 2'h1, F_XW, 32'hFF01_0000, 32'h0);
        chk("idx24 ea", ext ? 32'h0002_0000 : 32'h0001_0000, ea_o);
        go(AM_PCREL, 3'h0, 3'h0, 2'h1, F_XB, 32'h0000_B000, 32'h1959_080B);
        chk("rel16 pc", ext ? 32'h1958_B80B : 32'h0000_B80B, pc_o);
    endtask : s_relative

    initial
    begin
        reset_n_i = 1'b0;
        {set_gw, clr_gw, ext_go, start_i, reg_wr_i} = 5'h0;
        {io_i, jump_i, opw_i, xb_i, xw_i, wd_i, ld_i, we_i} = 8'h0;
        addr_mode_i = AM_REG;
        {base_i, src_i, dst_i, wsel_i, rsel_i, bidx} = 17'h0;
        {pc_i, wdata_i, ibytes} = 96'h0;
        {n_errors, compares, nmem, last_io, got_pcl} = 0;
        mem[32'h0000_5E22] = 8'h01;
        mem[32'h0000_5E23] = 8'h03;
        for (int i = 0; i < 4; i++)
            mem[32'h1234_5E22 + i] = 8'h01 + 8'h02 * i[7:0];
        mem[32'h0000_0001] = 8'h3C;
        mem[32'h1234_5678] = 8'h0B;
        repeat (20) @(posedge clk_i);
        reset_n_i <= 1'b1;
        @(negedge clk_i);
        chk("width at reset", 32'h0, gw_o);
        chk("mode at reset", 32'h0, ext_o);
        rd("upper half reset", `REG_IX, 32'h0);
        wr(`REG_BC, 32'h1234_5678);
        wr(`REG_HL, 32'h9ABC_DEF0);
        wr(`REG_IX, 32'h0001_0000);
        wr(`REG_SP, 32'h07FF_7F00);
        s_global_width();
        s_loads();
        s_indirect();
        go(AM_IDX, `REG_IX, 3'h0, 2'h1, F_XB, 32'h0000_8000, 32'h0);
        chk("idx16 ea", 32'h0001_8000, ea_o);
        go(AM_SPREL, `REG_SP, 3'h0, 2'h1, 8'h00, 32'h0000_00FC, 32'h0);
        chk("sp rel ea", 32'h07FF_7EFC, ea_o);
        go(AM_PCREL, 3'h0, 3'h0, 2'h1, 8'h00, 32'h0000_0001, 32'h0000_FFFF);
        chk("rel wrap", 32'h0, pc_o);
        go(AM_PCREL, 3'h0, 3'h0, 2'h1, 8'h00, 32'h0000_00FE, 32'h0000_1000);
        chk("rel8 pc", 32'h0000_0FFE, pc_o);
        s_relative(1'b0);
        pulse(2);
        chk("extended set", 32'h1, ext_o);
        s_relative(1'b1);
        finish_test();
    end
endmodule : operand_address_generation_test
